// ---- verilog/tbpwm_defines.svh ----
/*
  Register offsets, field positions, reset values and timing counts of the
  timer based PWM unit.
  Assumes an 8-bit register port and a core clock equal to the oscillator.
*/
`ifndef TBPWM_DEFINES_SVH
`define TBPWM_DEFINES_SVH

// ============================================================
// register offsets
`define TBPWM_ADDR_PORT_DATA 8'h06
`define TBPWM_ADDR_INT_CTL 8'h0b
`define TBPWM_ADDR_TIMER 8'h11
`define TBPWM_ADDR_TIMER_CTL 8'h12
`define TBPWM_ADDR_DUTY_HI 8'h15
`define TBPWM_ADDR_SHADOW 8'h16
`define TBPWM_ADDR_CCP_CTL 8'h17
`define TBPWM_ADDR_PORT_DIR 8'h86
`define TBPWM_ADDR_PERIOD 8'h92

// ============================================================
// field positions
`define TBPWM_CTL_DLO_HI 5
`define TBPWM_CTL_DLO_LO 4
`define TBPWM_CTL_MODE_HI 3
`define TBPWM_CTL_MODE_LO 2
`define TBPWM_T2_ON 2
`define TBPWM_T2_PS_HI 1
`define TBPWM_T2_PS_LO 0
`define TBPWM_PIN_ALT 3
`define TBPWM_PIN_MAIN 0

// ============================================================
// reset values and the PWM mode code
`define TBPWM_RST_PERIOD 8'hff
`define TBPWM_RST_PORT_DIR 8'hff
`define TBPWM_RST_BYTE 8'h00
`define TBPWM_RST_CTL 6'h00
`define TBPWM_RST_T2 7'h00
`define TBPWM_MODE_PWM 2'h3

// ============================================================
// timing counts
`define TBPWM_Q_LAST 2'h3
`define TBPWM_STRAP_WAIT 2'h2

`endif

// ---- verilog/tbpwm_pkg.sv ----
/*
  Types of the timer based PWM unit.
  Assumes tbpwm_defines.svh is compiled alongside.
*/
package tbpwm_pkg;

  // ============================================================
  // prescale selection
  typedef enum logic [1:0] {
    TBPWM_PS_1 = 2'b00,
    TBPWM_PS_4 = 2'b01,
    TBPWM_PS_16 = 2'b10,
    TBPWM_PS_16B = 2'b11
  } tbpwm_ps_t;

  // ============================================================
  // whole state of the unit
  typedef struct packed {
    logic [7:0] period_reg;
    logic [7:0] timer_reg;
    logic [7:0] duty_hi_reg;
    logic [7:0] shadow_reg;
    logic [1:0] lat2_reg;
    logic [5:0] ctl_reg;
    logic [6:0] timer_control_register_reg;
    logic [7:0] dir_reg;
    logic [7:0] port_lat_reg;
    logic [7:0] intctl_reg;
    logic [1:0] q_reg;
    logic [3:0] pre_reg;
    logic sync1_reg;
    logic sync2_reg;
    logic [1:0] strap_cnt_reg;
    logic strap_reg;
    logic out_reg;
    logic [7:0] rdata_reg;
    logic [7:0] port_out_reg;
    logic [7:0] port_oe_b_reg;
  } tbpwm_state_t;

endpackage

// ---- verilog/tbpwm_unit.sv ----
/*
  Timer based PWM unit: 8-bit period timer with prescaler, double-buffered
  10-bit duty and the port pins it shares.
  Assumes a plain register port on clk, an asynchronous strap pin that
  selects the output bit, and an outside wire resolver for the port pins.
*/
`timescale 1ns/100ps
`include "tbpwm_defines.svh"

module tbpwm_unit
  import tbpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic output_pin_select_bit,
  output logic [7:0] port_out,
  output logic [7:0] port_oe_b
);

  // ============================================================
  // helpers

  // fine bits below the timer count, from clock phase or prescaler
  function automatic logic [1:0] fine_of(input tbpwm_ps_t ps,
                                         input logic [1:0] q,
                                         input logic [3:0] pre);
    logic [1:0] f;
    f = q;
    case (ps)
      TBPWM_PS_1: begin
        f = q;
      end
      TBPWM_PS_4: begin
        f = pre[1:0];
      end
      default: begin
        f = pre[3:2];
      end
    endcase
    return f;
  endfunction

  function automatic logic is_pwm(input logic [5:0] ctl);
    return ctl[`TBPWM_CTL_MODE_HI:`TBPWM_CTL_MODE_LO] == `TBPWM_MODE_PWM;
  endfunction

  // ============================================================
  // state

  tbpwm_state_t s_reg;
  tbpwm_state_t s_next;
  tbpwm_ps_t ps;
  logic tick;
  logic rollover;
  logic timer_on;
  logic pwm_mode;
  logic [9:0] ext_next;
  logic [9:0] duty_full;
  logic [9:0] buf_full;
  logic wr_ctl_zero;

  always_comb begin
    s_next = s_reg;
    ps = tbpwm_ps_t'(s_reg.timer_control_register_reg[`TBPWM_T2_PS_HI:`TBPWM_T2_PS_LO]);
    timer_on = s_reg.timer_control_register_reg[`TBPWM_T2_ON];
    tick = 1'b0;
    duty_full = {s_reg.duty_hi_reg,
                 s_reg.ctl_reg[`TBPWM_CTL_DLO_HI:`TBPWM_CTL_DLO_LO]};
    wr_ctl_zero = 1'b0;

    // clock phase always runs; it is the quarter-cycle source
    s_next.q_reg = s_reg.q_reg + 2'h1;

    // prescaler advances once per instruction cycle
    if (timer_on && s_reg.q_reg == `TBPWM_Q_LAST) begin
      s_next.pre_reg = s_reg.pre_reg + 4'h1;
      case (ps)
        TBPWM_PS_1: begin
          tick = 1'b1;
        end
        TBPWM_PS_4: begin
          tick = s_reg.pre_reg[1:0] == 2'h3;
        end
        default: begin
          tick = s_reg.pre_reg == 4'hf;
        end
      endcase
    end

    // postscaler bits are stored only and never reach this path
    rollover = tick && s_reg.timer_reg == s_reg.period_reg;

    if (tick) begin
      if (rollover) begin
        s_next.timer_reg = 8'h00;
        s_next.shadow_reg = s_reg.duty_hi_reg;
        s_next.lat2_reg =
          s_reg.ctl_reg[`TBPWM_CTL_DLO_HI:`TBPWM_CTL_DLO_LO];
      end else begin
        s_next.timer_reg = s_reg.timer_reg + 8'h01;
      end
    end

    // ============================================================
    // register writes
    if (wr_en) begin
      case (addr)
        `TBPWM_ADDR_PORT_DATA: begin
          s_next.port_lat_reg = wdata;
        end
        `TBPWM_ADDR_INT_CTL: begin
          s_next.intctl_reg = wdata;
        end
        `TBPWM_ADDR_TIMER: begin
          // a timer write restarts the prescaler
          s_next.timer_reg = wdata;
          s_next.pre_reg = 4'h0;
        end
        `TBPWM_ADDR_TIMER_CTL: begin
          s_next.timer_control_register_reg = wdata[6:0];
        end
        `TBPWM_ADDR_DUTY_HI: begin
          s_next.duty_hi_reg = wdata;
        end
        `TBPWM_ADDR_SHADOW: begin
          if (!is_pwm(s_reg.ctl_reg)) begin
            s_next.shadow_reg = wdata;
          end
        end
        `TBPWM_ADDR_CCP_CTL: begin
          s_next.ctl_reg = wdata[5:0];
          wr_ctl_zero = wdata[5:0] == 6'h00;
        end
        `TBPWM_ADDR_PORT_DIR: begin
          s_next.dir_reg = wdata;
        end
        `TBPWM_ADDR_PERIOD: begin
          s_next.period_reg = wdata;
        end
        default: begin
        end
      endcase
    end

    // ============================================================
    // output latch

    // mode is taken after the write so that turning off acts at once
    pwm_mode = is_pwm(s_next.ctl_reg);
    ext_next = {s_next.timer_reg,
                fine_of(ps, s_next.q_reg, s_next.pre_reg)};
    buf_full = {s_reg.shadow_reg, s_reg.lat2_reg};

    if (!pwm_mode || wr_ctl_zero) begin
      s_next.out_reg = 1'b0;
    end else if (rollover) begin
      s_next.out_reg = duty_full != 10'h000;
    end else if (timer_on && ext_next == buf_full) begin
      // a duty past the period end never meets this compare
      s_next.out_reg = 1'b0;
    end

    // ============================================================
    // strap: two flops, then caught once after reset release
    s_next.sync1_reg = output_pin_select_bit;
    s_next.sync2_reg = s_reg.sync1_reg;
    // counter parks past the wait, so a later strap edge is never taken
    if (s_reg.strap_cnt_reg < `TBPWM_STRAP_WAIT) begin
      s_next.strap_cnt_reg = s_reg.strap_cnt_reg + 2'h1;
    end else if (s_reg.strap_cnt_reg == `TBPWM_STRAP_WAIT) begin
      s_next.strap_reg = s_reg.sync2_reg;
      s_next.strap_cnt_reg = `TBPWM_STRAP_WAIT + 2'h1;
    end

    // ============================================================
    // pins: the PWM latch takes over one port bit in PWM mode
    s_next.port_out_reg = s_next.port_lat_reg;
    if (pwm_mode) begin
      if (s_reg.strap_reg) begin
        s_next.port_out_reg[`TBPWM_PIN_ALT] = s_next.out_reg;
      end else begin
        s_next.port_out_reg[`TBPWM_PIN_MAIN] = s_next.out_reg;
      end
    end
    // direction bit set means input, so it is the enable as is
    s_next.port_oe_b_reg = s_next.dir_reg;

    // ============================================================
    // register reads, data one cycle after the strobe
    s_next.rdata_reg = 8'h00;
    if (rd_en) begin
      case (addr)
        `TBPWM_ADDR_PORT_DATA: begin
          s_next.rdata_reg = s_reg.port_lat_reg;
        end
        `TBPWM_ADDR_INT_CTL: begin
          s_next.rdata_reg = s_reg.intctl_reg;
        end
        `TBPWM_ADDR_TIMER: begin
          s_next.rdata_reg = s_reg.timer_reg;
        end
        `TBPWM_ADDR_TIMER_CTL: begin
          s_next.rdata_reg = {1'b0, s_reg.timer_control_register_reg};
        end
        `TBPWM_ADDR_DUTY_HI: begin
          s_next.rdata_reg = s_reg.duty_hi_reg;
        end
        `TBPWM_ADDR_SHADOW: begin
          s_next.rdata_reg = s_reg.shadow_reg;
        end
        `TBPWM_ADDR_CCP_CTL: begin
          s_next.rdata_reg = {2'b00, s_reg.ctl_reg};
        end
        `TBPWM_ADDR_PORT_DIR: begin
          s_next.rdata_reg = s_reg.dir_reg;
        end
        `TBPWM_ADDR_PERIOD: begin
          s_next.rdata_reg = s_reg.period_reg;
        end
        default: begin
          s_next.rdata_reg = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '{
        period_reg: `TBPWM_RST_PERIOD,
        timer_reg: `TBPWM_RST_BYTE,
        duty_hi_reg: `TBPWM_RST_BYTE,
        shadow_reg: `TBPWM_RST_BYTE,
        lat2_reg: 2'h0,
        ctl_reg: `TBPWM_RST_CTL,
        timer_control_register_reg: `TBPWM_RST_T2,
        dir_reg: `TBPWM_RST_PORT_DIR,
        port_lat_reg: `TBPWM_RST_BYTE,
        intctl_reg: `TBPWM_RST_BYTE,
        q_reg: 2'h0,
        pre_reg: 4'h0,
        sync1_reg: 1'b0,
        sync2_reg: 1'b0,
        strap_cnt_reg: 2'h0,
        strap_reg: 1'b0,
        out_reg: 1'b0,
        rdata_reg: `TBPWM_RST_BYTE,
        port_out_reg: `TBPWM_RST_BYTE,
        port_oe_b_reg: `TBPWM_RST_PORT_DIR
      };
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata_reg;
  assign port_out = s_reg.port_out_reg;
  assign port_oe_b = s_reg.port_oe_b_reg;

  // ============================================================
  // checks

  a_timer_clear: assert property (@(posedge clk) disable iff (!rst_b)
    rollover && !(wr_en && addr == `TBPWM_ADDR_TIMER)
      |=> s_reg.timer_reg == 8'h00)
    else $error("timer not cleared at period match");

  a_shadow_load: assert property (@(posedge clk) disable iff (!rst_b)
    rollover && !(wr_en && addr == `TBPWM_ADDR_SHADOW)
      |=> {s_reg.shadow_reg, s_reg.lat2_reg} == $past(duty_full))
    else $error("duty not buffered at rollover");

  a_pin_set: assert property (@(posedge clk) disable iff (!rst_b)
    rollover && is_pwm(s_reg.ctl_reg) && !wr_en && duty_full != 10'h000
      |=> s_reg.out_reg)
    else $error("output not set at rollover");

  a_zero_duty: assert property (@(posedge clk) disable iff (!rst_b)
    rollover && duty_full == 10'h000 |=> !s_reg.out_reg)
    else $error("output set with zero duty");

  a_shadow_ro: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en && addr == `TBPWM_ADDR_SHADOW && is_pwm(s_reg.ctl_reg) && !rollover
      |=> $stable(s_reg.shadow_reg))
    else $error("shadow written in PWM mode");

  a_match_clear: assert property (@(posedge clk) disable iff (!rst_b)
    timer_on && !rollover && ext_next == buf_full |=> !s_reg.out_reg)
    else $error("output not cleared on duty match");

  a_mode_off: assert property (@(posedge clk) disable iff (!rst_b)
    !is_pwm(s_reg.ctl_reg) && !wr_en
      |=> !s_reg.out_reg && port_out == s_reg.port_lat_reg)
    else $error("output active outside PWM mode");

  a_ctl_clear: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en && addr == `TBPWM_ADDR_CCP_CTL && wdata[5:0] == 6'h00
      |=> !s_reg.out_reg)
    else $error("control clear did not force output low");

  a_tick_rate: assert property (@(posedge clk) disable iff (!rst_b)
    tick && ps == TBPWM_PS_4 |-> s_reg.pre_reg[1:0] == 2'h3
      && s_reg.q_reg == `TBPWM_Q_LAST)
    else $error("prescale 4 tick misplaced");

  a_pin_follow: assert property (@(posedge clk) disable iff (!rst_b)
    s_reg.strap_cnt_reg == 2'h3 && $past(s_reg.strap_cnt_reg) == 2'h3
      && is_pwm(s_reg.ctl_reg)
      |-> (s_reg.strap_reg ? port_out[`TBPWM_PIN_ALT]
        : port_out[`TBPWM_PIN_MAIN]) == s_reg.out_reg)
    else $error("pwm latch missing from port");

  a_read_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !rd_en |=> rdata == 8'h00)
    else $error("read data standing without a read");

  a_tick_gap: assert property (@(posedge clk) disable iff (!rst_b)
    tick |=> (!tick) [*3])
    else $error("timer ticks closer than one instruction cycle");

  a_timer_step: assert property (@(posedge clk) disable iff (!rst_b)
    tick && !rollover && !(wr_en && addr == `TBPWM_ADDR_TIMER)
      |=> s_reg.timer_reg == $past(s_reg.timer_reg) + 8'h01)
    else $error("timer did not step on a tick");

  a_shadow_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !rollover && !(wr_en && addr == `TBPWM_ADDR_SHADOW)
      |=> $stable(s_reg.shadow_reg) && $stable(s_reg.lat2_reg))
    else $error("buffered duty changed inside a period");

  a_out_hold: assert property (@(posedge clk) disable iff (!rst_b)
    is_pwm(s_reg.ctl_reg) && !wr_en && !rollover
      && !(timer_on && ext_next == buf_full)
      |=> $stable(s_reg.out_reg))
    else $error("output moved between period events");

  a_dir_drive: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en && addr == `TBPWM_ADDR_PORT_DIR
      |=> port_oe_b == $past(wdata))
    else $error("pin enables do not follow direction write");

endmodule // tbpwm_unit

// ---- verification/tbpwm_load.sv ----
/*
  Load on the PWM pin: measures the last high time and the last period,
  both in clocks.
  Assumes the bench resolves the pin level, pulled low while undriven.
*/
`timescale 1ns/100ps

module tbpwm_load (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic [15:0] hi_len,
  output logic [15:0] per_len
);
  logic prev_reg;
  logic [15:0] hi_c;
  logic [15:0] per_c;

  // ============================================================
  // edge timing
  // only looks at the pin, so the load can never disturb the output
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 1'b0;
      hi_c <= 16'h0000;
      per_c <= 16'h0000;
      hi_len <= 16'h0000;
      per_len <= 16'h0000;
    end else begin
      prev_reg <= pin;
      if (pin && !prev_reg) begin
        per_len <= per_c;
        per_c <= 16'h0001;
        hi_c <= 16'h0001;
      end else begin
        per_c <= per_c + 16'h0001;
        if (pin) begin
          hi_c <= hi_c + 16'h0001;
        end
      end
      if (!pin && prev_reg) begin
        hi_len <= hi_c;
      end
    end
  end
endmodule // tbpwm_load

// ---- verification/tbpwm_unit_bench.sv ----
/*
  Self-checking bench of the timer based PWM unit.
  Assumes the register port of the design and a load model on the pin.
*/
`timescale 1ns/100ps
`include "tbpwm_defines.svh"

module tbpwm_unit_bench;
  logic clk;
  logic rst_b;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [7:0] rdata;
  logic strap;
  logic [7:0] port_out;
  logic [7:0] port_oe_b;
  logic [2:0] sel;
  logic pin_lvl;
  logic [15:0] hi_len;
  logic [15:0] per_len;
  logic [7:0] d;
  int n_errors;
  int checks_done;
  logic [1:0] t_ps [3] = '{2'b00, 2'b01, 2'b10};
  logic [7:0] t_pr [3] = '{8'h03, 8'h01, 8'h00};
  logic [9:0] t_du [3] = '{10'h005, 10'h006, 10'h003};
  logic [15:0] t_per [3] = '{16'd16, 16'd32, 16'd64};
  logic [15:0] t_hi [3] = '{16'd5, 16'd24, 16'd48};

  // undriven pin falls to the pull-down level
  assign pin_lvl = port_oe_b[sel] ? 1'b0 : port_out[sel];

  always #5 clk = ~clk;

  tbpwm_unit u_dut (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .output_pin_select_bit(strap),
    .port_out(port_out), .port_oe_b(port_oe_b)
  );

  tbpwm_load u_load (
    .clk(clk), .rst_b(rst_b), .pin(pin_lvl),
    .hi_len(hi_len), .per_len(per_len)
  );

  // ============================================================
  // access and compare tasks
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e,
                      input string what);
    logic [7:0] v;
    rd(a, v);
    chk(what, {8'h00, e}, {8'h00, v});
  endtask

  // bounded wait for a rising pin; running out ends the run
  task automatic wait_rise;
    logic seen;
    logic last;
    seen = 1'b0;
    last = pin_lvl;
    for (int k = 0; k < 3000 && !seen; k++) begin
      @(posedge clk);
      #1;
      seen = (pin_lvl === 1'b1) && (last === 1'b0);
      last = pin_lvl;
    end
    if (!seen) begin
      n_errors++;
      $display("[ERR] pin rise expected 1 seen 0");
      report_and_stop;
    end
  endtask

  // postscale bits are set on purpose: they must not move the period
  task automatic cfg(input logic [1:0] ps, input logic [7:0] pr,
                     input logic [9:0] du, input logic [7:0] dir);
    wr(`TBPWM_ADDR_CCP_CTL, 8'h00);
    wr(`TBPWM_ADDR_TIMER_CTL, 8'h00);
    wr(`TBPWM_ADDR_TIMER, 8'h00);
    wr(`TBPWM_ADDR_PERIOD, pr);
    wr(`TBPWM_ADDR_DUTY_HI, du[9:2]);
    wr(`TBPWM_ADDR_CCP_CTL, {2'b00, du[1:0], 4'h0});
    wr(`TBPWM_ADDR_PORT_DIR, dir);
    wr(`TBPWM_ADDR_TIMER_CTL, {6'h1f, ps});
    wr(`TBPWM_ADDR_CCP_CTL, {2'b00, du[1:0], 4'hc});
  endtask

  task automatic measure(input logic [7:0] pr, input logic [15:0] ep,
                         input logic [15:0] eh);
    logic [7:0] t;
    wait_rise;
    wait_rise;
    wait_rise;
    rd(`TBPWM_ADDR_TIMER, t);
    chk("timer within period", 16'h0001, {15'h0000, t <= pr});
    chk("period clocks", ep, per_len);
    chk("high clocks", eh, hi_len);
  endtask

  // ============================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    strap = 1'b0;
    sel = 3'd0;
    n_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rchk(`TBPWM_ADDR_PERIOD, 8'hff, "period reset");
    rchk(`TBPWM_ADDR_PORT_DIR, 8'hff, "direction reset");
    rchk(`TBPWM_ADDR_CCP_CTL, 8'h00, "control reset");
    rchk(8'h40, 8'h00, "unmapped read");
    wr(`TBPWM_ADDR_INT_CTL, 8'ha5);
    rchk(`TBPWM_ADDR_INT_CTL, 8'ha5, "interrupt control");
    @(posedge clk);
    #1;
    chk("read data after strobe", 16'h0000, {8'h00, rdata});
    for (int i = 0; i < 3; i++) begin
      cfg(t_ps[i], t_pr[i], t_du[i], 8'hfe);
      measure(t_pr[i], t_per[i], t_hi[i]);
    end
    // clear early in the high time, then re-enter: latch must stay low
    wait_rise;
    wr(`TBPWM_ADDR_CCP_CTL, 8'h00);
    #1;
    chk("latch after clear", 16'h0000, {15'h0000, port_out[0]});
    wr(`TBPWM_ADDR_CCP_CTL, 8'h3c);
    #1;
    chk("latch low on re-entry", 16'h0000, {15'h0000, pin_lvl});
    wr(`TBPWM_ADDR_CCP_CTL, 8'h00);
    wr(`TBPWM_ADDR_PORT_DATA, 8'h01);
    #1;
    chk("pin follows port", 16'h0001, {15'h0000, port_out[0]});
    wr(`TBPWM_ADDR_PORT_DATA, 8'h00);
    cfg(2'b00, 8'h03, 10'h000, 8'hfe);
    d = 8'h00;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk);
      #1;
      d = d | {7'h00, pin_lvl};
    end
    chk("zero duty high seen", 16'h0000, {8'h00, d});
    cfg(2'b00, 8'h01, 10'h009, 8'hfe);
    wait_rise;
    d = 8'h00;
    for (int k = 0; k < 64; k++) begin
      @(posedge clk);
      #1;
      d = d | {7'h00, ~pin_lvl};
    end
    chk("long duty low seen", 16'h0000, {8'h00, d});
    cfg(2'b00, 8'h3f, 10'h040, 8'hfe);
    wait_rise;
    wait_rise;
    wr(`TBPWM_ADDR_DUTY_HI, 8'h20);
    rchk(`TBPWM_ADDR_SHADOW, 8'h10, "shadow mid period");
    wr(`TBPWM_ADDR_SHADOW, 8'h55);
    rchk(`TBPWM_ADDR_SHADOW, 8'h10, "shadow after write");
    wait_rise;
    wait_rise;
    rchk(`TBPWM_ADDR_SHADOW, 8'h20, "shadow after rollover");
    chk("new high clocks", 16'd128, hi_len);
    // strap is only captured after reset, so pick bit 3 across one
    rst_b <= 1'b0;
    strap <= 1'b1;
    sel <= 3'd3;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    cfg(2'b00, 8'h03, 10'h005, 8'hf7);
    measure(8'h03, 16'd16, 16'd5);
    chk("bit 0 released", 16'h0001, {15'h0000, port_oe_b[0]});
    report_and_stop;
  end
endmodule // tbpwm_unit_bench
